// ---- uvr_pkg.sv ----
// constants and carrier types for the undervoltage recorded-data block
package uvr_pkg;
    localparam int          VW          = 10;        // voltage in 0.01 x rated
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_KMULT     = 8'h04;
    localparam logic [7:0]  A_TLOW      = 8'h08;
    localparam logic [7:0]  A_TDEEP     = 8'h0c;
    localparam logic [7:0]  A_USTART    = 8'h10;
    localparam logic [7:0]  A_BUSADDR   = 8'h14;
    localparam logic [7:0]  A_RATE      = 8'h18;
    localparam logic [7:0]  A_PASSWD    = 8'h1c;
    localparam logic [7:0]  A_REC1      = 8'h20;     // rec1..rec8 at 0x20..0x3c
    localparam logic [7:0]  A_REC5      = 8'h30;
    localparam logic [7:0]  A_REC7      = 8'h38;
    localparam logic [7:0]  A_REG0      = 8'h40;
    localparam logic [7:0]  A_STATUS    = 8'h44;
    localparam int          CTRL_INV    = 0;
    localparam int          CTRL_CLR    = 1;
    localparam logic [9:0]  KMULT_RST   = 10'h064;   // 1.00
    localparam logic [15:0] TLOW_RST    = 16'h0064;  // 10 ms units
    localparam logic [15:0] TDEEP_RST   = 16'h0064;
    localparam logic [9:0]  USTART_RST  = 10'h050;   // 0.80 x rated
    localparam logic [9:0]  VMAX_RST    = 10'h3ff;
    localparam logic [7:0]  CNT_MAX     = 8'hff;
    localparam logic [6:0]  PCT_FULL    = 7'h64;     // 100 percent
    localparam logic [6:0]  PCT_CAP     = 7'h63;
    localparam int          INV_A       = 480;
    localparam int          INV_B       = 32;
    localparam logic [9:0]  INV_MIN_DROP = 10'h006;  // 6 percent
    localparam int          TICK_MS     = 10;
    localparam int          CLK_KHZ     = 10000;
    localparam int          TICK_CYC    = TICK_MS * CLK_KHZ;
    localparam int          DARK_S      = 300;
    localparam int          DARK_TICKS  = DARK_S * 1000 / TICK_MS;
    localparam logic [3:0]  DIG_A       = 4'ha;
    localparam logic [1:0]  SUB_ADDR    = 2'h0;
    localparam logic [1:0]  SUB_RATE    = 2'h1;
    localparam logic [1:0]  SUB_MON     = 2'h2;
    localparam logic [1:0]  SUB_PW      = 2'h3;

    typedef enum logic [1:0] {SER_NONE, SER_PASSWORD, SER_CLEAR, SER_SET_K} uvr_ser_e;

    typedef struct packed {
        logic [VW-1:0] u12;
        logic [VW-1:0] u23;
        logic [VW-1:0] u31;
    } uvr_volt_s;

    typedef struct packed {
        logic low_start;
        logic low_trip;
        logic deep_start;
        logic deep_trip;
        logic low_block;
        logic deep_block;
    } uvr_stage_s;

    typedef struct packed {
        uvr_ser_e    kind;
        logic [15:0] value;
    } uvr_ser_s;

    typedef struct packed {
        logic [3:0]    digit;
        logic [VW-1:0] value;
        logic          dashes;
        logic          lit;
    } uvr_disp_s;
endpackage

// ---- uvr_rec.sv ----
// recorded-data registers, display and serial gate of the undervoltage module
//
// The register offsets and register access over APB were left to the implementer.
module uvr_rec #(
    parameter int TICK_CYCLES = uvr_pkg::TICK_CYC
) (
    input  wire logic               core_clk_i,
    input  wire logic               rstn_i,
    input  wire logic               ce_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic [31:0]             prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire uvr_pkg::uvr_volt_s volt_i,
    input  wire uvr_pkg::uvr_stage_s stage_i,
    input  wire uvr_pkg::uvr_ser_s  ser_i,
    input  wire logic               step_btn_i,
    input  wire logic               reset_btn_i,
    input  wire logic               remote_reset_i,
    input  wire logic               link_ok_i,
    input  wire logic [7:0]         nv_bus_addr_i,
    input  wire logic [2:0]         nv_rate_i,
    input  wire logic [15:0]        nv_passwd_i,
    output uvr_pkg::uvr_disp_s      disp_o,
    output logic [3:0]              test_out_o,
    output logic                    set_reject_o
);
    import uvr_pkg::*;

    // pin synchronisers
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic       step_d;
    logic       rst_d;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sy1    <= 4'h0;
            sy2    <= 4'h0;
            step_d <= 1'b0;
            rst_d  <= 1'b0;
        end else if (ce_i) begin
            sy1    <= {link_ok_i, remote_reset_i, reset_btn_i, step_btn_i};
            sy2    <= sy1;
            step_d <= sy2[0];
            rst_d  <= sy2[1];
        end
    end
    wire step_s    = sy2[0];
    wire rbtn_s    = sy2[1];
    wire rremote_s = sy2[2];
    wire link_s    = sy2[3];
    wire step_p    = step_s & ~step_d;
    wire rbtn_p    = rbtn_s & ~rst_d;
    wire combo_p   = (step_p & rbtn_s) | (rbtn_p & step_s);

    // apb decode
    wire       acc    = psel_i & penable_i & pready_o;
    wire       wr     = acc & pwrite_i;
    wire       mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= A_STATUS);
    wire       ro_hit = (paddr_i >= A_REC1);

    // settings
    logic        inv_sel;
    logic [9:0]  kmult;
    logic [15:0] t_low;
    logic [15:0] t_deep;
    logic [9:0]  u_start;
    logic [7:0]  bus_addr;
    logic [2:0]  rate;
    logic [15:0] passwd;
    logic        nv_pend;
    logic        pw_ok;
    wire ser_pw  = (ser_i.kind == SER_PASSWORD);
    wire ser_clr = (ser_i.kind == SER_CLEAR);
    wire ser_k   = (ser_i.kind == SER_SET_K);
    wire sw_clr  = wr && (paddr_i == A_CTRL) && pwdata_i[CTRL_CLR];
    wire clr     = combo_p | ser_clr | sw_clr;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            inv_sel <= 1'b0;
            kmult   <= KMULT_RST;
            t_low   <= TLOW_RST;
            t_deep  <= TDEEP_RST;
            u_start <= USTART_RST;
        end else if (ce_i) begin
            if (wr && paddr_i == A_CTRL) inv_sel <= pwdata_i[CTRL_INV];
            if (wr && paddr_i == A_TLOW) t_low <= pwdata_i[15:0];
            if (wr && paddr_i == A_TDEEP) t_deep <= pwdata_i[15:0];
            if (wr && paddr_i == A_USTART) u_start <= pwdata_i[9:0];
            if (wr && paddr_i == A_KMULT) begin
                kmult <= pwdata_i[9:0];
            end else if (ser_k && pw_ok) begin
                kmult <= ser_i.value[9:0];
            end
        end
    end

    // nonvolatile image reloaded after power returns
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nv_pend      <= 1'b1;
            bus_addr     <= 8'h00;
            rate         <= 3'h0;
            passwd       <= 16'h0000;
            pw_ok        <= 1'b0;
            set_reject_o <= 1'b0;
        end else if (ce_i) begin
            if (nv_pend) begin
                nv_pend  <= 1'b0;
                bus_addr <= nv_bus_addr_i;
                rate     <= nv_rate_i;
                passwd   <= nv_passwd_i;
            end else begin
                if (wr && paddr_i == A_BUSADDR) bus_addr <= pwdata_i[7:0];
                if (wr && paddr_i == A_RATE) rate <= pwdata_i[2:0];
                if (wr && paddr_i == A_PASSWD) passwd <= pwdata_i[15:0];
            end
            if (ser_pw) pw_ok <= (ser_i.value == passwd);
            if (ser_k) set_reject_o <= ~pw_ok;
        end
    end

    // phase extremes
    wire [9:0] lo01  = (volt_i.u12 < volt_i.u23) ? volt_i.u12 : volt_i.u23;
    wire [9:0] v_min = (lo01 < volt_i.u31) ? lo01 : volt_i.u31;
    wire [9:0] hi01  = (volt_i.u12 > volt_i.u23) ? volt_i.u12 : volt_i.u23;
    wire [9:0] v_max = (hi01 > volt_i.u31) ? hi01 : volt_i.u31;

    // inverse time: t[10 ms] = k[0.01] * 480 / drop[%] + 32
    wire [9:0]  drop    = (v_min < u_start) ? (u_start - v_min) : 10'h000;
    wire [19:0] drop_pc = (20'(drop) * 20'd100) / ((u_start == 10'h000) ? 20'd1 : 20'(u_start));
    wire        inv_go  = drop_pc >= 20'(INV_MIN_DROP);
    wire [19:0] inv_t   = (20'(kmult) * 20'(INV_A)) / (inv_go ? drop_pc : 20'd1)
                          + 20'(INV_B);
    wire [19:0] op_low  = inv_sel ? inv_t : 20'(t_low);
    wire        low_run = stage_i.low_start & ~stage_i.low_trip & (~inv_sel | inv_go);

    // time base
    logic [$clog2(TICK_CYCLES)-1:0] pre;
    wire tick = (pre == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

    // recorded registers
    logic [9:0]  rec_min_low;
    logic [9:0]  rec_vmax;
    logic [9:0]  rec_min_deep;
    logic        deep_seen;
    logic [9:0]  rec_vmin;
    logic [7:0]  n_low;
    logic [7:0]  n_deep;
    logic [6:0]  pct_low;
    logic [6:0]  pct_deep;
    logic [19:0] acc_low;
    logic [19:0] acc_deep;
    logic        ls_d;
    logic        ds_d;
    wire ls_rise = stage_i.low_start & ~ls_d;
    wire ds_rise = stage_i.deep_start & ~ds_d;
    wire [19:0] nacc_low  = acc_low + 20'd100;
    wire [19:0] nacc_deep = acc_deep + 20'd100;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre  <= '0;
            ls_d <= 1'b0;
            ds_d <= 1'b0;
        end else if (ce_i) begin
            pre  <= tick ? '0 : pre + 1'b1;
            ls_d <= stage_i.low_start;
            ds_d <= stage_i.deep_start;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rec_min_low  <= 10'h000;
            rec_vmax     <= 10'h000;
            rec_min_deep <= VMAX_RST;
            deep_seen    <= 1'b0;
            rec_vmin     <= VMAX_RST;
            n_low        <= 8'h00;
            n_deep       <= 8'h00;
        end else if (ce_i) begin
            if (clr) begin
                rec_min_low  <= 10'h000;
                rec_vmax     <= 10'h000;
                rec_min_deep <= VMAX_RST;
                deep_seen    <= 1'b0;
                rec_vmin     <= VMAX_RST;
                n_low        <= 8'h00;
                n_deep       <= 8'h00;
            end else begin
                if (v_max > rec_vmax) rec_vmax <= v_max;
                if (v_min < rec_vmin) rec_vmin <= v_min;
                if (ls_rise) begin
                    rec_min_low <= v_min;
                end else if (stage_i.low_start && !stage_i.low_trip && v_min < rec_min_low) begin
                    rec_min_low <= v_min;
                end
                if (ds_rise) begin
                    rec_min_deep <= v_max;
                    deep_seen    <= 1'b1;
                end else if (stage_i.deep_start && !stage_i.deep_trip
                             && v_max < rec_min_deep) begin
                    rec_min_deep <= v_max;
                end
                if (ls_rise && n_low != CNT_MAX) n_low <= n_low + 8'h01;
                if (ds_rise && n_deep != CNT_MAX) n_deep <= n_deep + 8'h01;
            end
        end
    end

    // duration in percent: add 100 per tick, one percent per operate-time worth
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pct_low  <= 7'h00;
            pct_deep <= 7'h00;
            acc_low  <= 20'h00000;
            acc_deep <= 20'h00000;
        end else if (ce_i) begin
            if (clr || ls_rise) begin
                pct_low <= 7'h00;
                acc_low <= 20'h00000;
            end else if (stage_i.low_trip) begin
                pct_low <= PCT_FULL;
            end else if (tick && low_run && pct_low < PCT_CAP) begin
                if (nacc_low >= op_low) begin
                    acc_low <= nacc_low - op_low;
                    pct_low <= pct_low + 7'h01;
                end else begin
                    acc_low <= nacc_low;
                end
            end
            if (clr || ds_rise) begin
                pct_deep <= 7'h00;
                acc_deep <= 20'h00000;
            end else if (stage_i.deep_trip) begin
                pct_deep <= PCT_FULL;
            end else if (tick && stage_i.deep_start && pct_deep < PCT_CAP) begin
                if (nacc_deep >= 20'(t_deep)) begin
                    acc_deep <= nacc_deep - 20'(t_deep);
                    pct_deep <= pct_deep + 7'h01;
                end else begin
                    acc_deep <= nacc_deep;
                end
            end
        end
    end

    // register 0 image: hundreds remote reset, tens zero, units blocking
    wire [1:0] blk  = {stage_i.deep_block, stage_i.low_block};
    wire [9:0] reg0 = (rremote_s ? 10'd100 : 10'd0) + 10'(blk);
    // traffic monitor
    logic [7:0] mon;
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mon <= 8'h00;
        end else if (ce_i) begin
            if (link_s) mon <= 8'h00;
            else if (tick) mon <= mon + 8'h01;
        end
    end
    // front panel menu
    typedef enum logic [1:0] {M_DARK, M_REG, M_TEST} uvr_menu_e;
    uvr_menu_e   mode;
    logic [3:0]  sel;
    logic [1:0]  sub;
    logic [2:0]  tstep;
    logic [15:0] idle;
    wire [3:0] sel_nx = (sel == 4'h8) ? 4'h0 : (sel == 4'h0) ? DIG_A
                      : (sel == DIG_A) ? 4'h1 : sel + 4'h1;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode  <= M_REG;
            sel   <= 4'h1;
            sub   <= SUB_ADDR;
            tstep <= 3'h0;
            idle  <= 16'h0000;
        end else if (ce_i) begin
            if (step_p || rbtn_p) idle <= 16'h0000;
            else if (tick && idle != 16'(DARK_TICKS)) idle <= idle + 16'h0001;
            case (mode)
                M_DARK: begin
                    if (step_p) mode <= M_REG;
                end
                M_REG: begin
                    if (idle == 16'(DARK_TICKS)) begin
                        mode <= M_DARK;
                    end else if (!combo_p && step_p) begin
                        sel <= sel_nx;
                        sub <= SUB_ADDR;
                    end else if (!combo_p && rbtn_p && sel == 4'h0) begin
                        mode  <= M_TEST;
                        tstep <= 3'h0;
                    end else if (!combo_p && rbtn_p && sel == DIG_A) begin
                        sub <= sub + 2'h1;
                    end
                end
                M_TEST: begin
                    if (rbtn_p) mode <= M_REG;
                    else if (step_p) begin
                        if (tstep == 3'h4) mode <= M_REG;
                        tstep <= tstep + 3'h1;
                    end
                end
                default: mode <= M_REG;
            endcase
        end
    end

    wire [9:0] sub_val = (sub == SUB_ADDR) ? 10'(bus_addr) : (sub == SUB_RATE) ? 10'(rate)
                       : (sub == SUB_MON) ? 10'(mon) : 10'h000;
    wire [9:0] shown   = (sel == 4'h0) ? reg0 : (sel == DIG_A) ? sub_val
                       : rec_at(3'(sel - 4'h1));
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_o     <= '0;
            test_out_o <= 4'h0;
        end else if (ce_i) begin
            disp_o.digit  <= sel;
            disp_o.value  <= shown;
            disp_o.dashes <= (sel == 4'h3) && !deep_seen;
            disp_o.lit    <= (mode != M_DARK);
            test_out_o    <= (mode == M_TEST && tstep != 3'h0)
                             ? 4'(4'h1 << (tstep - 3'h1)) : 4'h0;
        end
    end
    // apb read mux
    logic [31:0] rd;
    always_comb begin
        case (paddr_i)
            A_CTRL:    rd = {31'h0, inv_sel};
            A_KMULT:   rd = {22'h0, kmult};
            A_TLOW:    rd = {16'h0, t_low};
            A_TDEEP:   rd = {16'h0, t_deep};
            A_USTART:  rd = {22'h0, u_start};
            A_BUSADDR: rd = {24'h0, bus_addr};
            A_RATE:    rd = {29'h0, rate};
            A_PASSWD:  rd = {16'h0, passwd};
            A_REG0:    rd = {22'h0, reg0};
            A_STATUS:  rd = {26'h0, deep_seen, pw_ok, 3'(mode), set_reject_o};
            default:   rd = (ro_hit && mapped && paddr_i < A_REG0)
                            ? {22'h0, rec_at(paddr_i[4:2])} : 32'h0;
        endcase
    end
    function automatic logic [9:0] rec_at(input logic [2:0] i);
        case (i)
            3'h0:    rec_at = rec_min_low;
            3'h1:    rec_at = rec_vmax;
            3'h2:    rec_at = rec_min_deep;
            3'h3:    rec_at = rec_vmin;
            3'h4:    rec_at = 10'(n_low);
            3'h5:    rec_at = 10'(n_deep);
            3'h6:    rec_at = 10'(pct_low);
            default: rec_at = 10'(pct_deep);
        endcase
    endfunction
    // one wait state; errors on any unmapped access and on read-only writes
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else if (ce_i) begin
            pready_o  <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o
                         & (~mapped | (pwrite_i & ro_hit));
            prdata_o  <= (psel_i & ~pwrite_i & mapped) ? rd : 32'h0;
        end
    end
endmodule // uvr_rec

// ---- uvr_rec_asserts.sv ----
// concurrent checks on the recorded-data block ports
module uvr_rec_asserts (
    input wire logic               core_clk_i,
    input wire logic               rstn_i,
    input wire logic               psel_i,
    input wire logic               penable_i,
    input wire logic               pwrite_i,
    input wire logic [7:0]         paddr_i,
    input wire logic [31:0]        prdata_o,
    input wire logic               pready_o,
    input wire logic               pslverr_o,
    input wire uvr_pkg::uvr_ser_s  ser_i,
    input wire logic [15:0]        nv_passwd_i,
    input wire uvr_pkg::uvr_disp_s disp_o,
    input wire logic [3:0]         test_out_o,
    input wire logic               set_reject_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import uvr_pkg::*;
    logic pw_good;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // remembers whether the last password sent was the right one
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pw_good <= 1'b0;
        end else if (ser_i.kind == SER_PASSWORD) begin
            pw_good <= ser_i.value == nv_passwd_i;
        end
    end
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    wire rd_done = pready_o && !pwrite_i;
    a_ready_late: assert property (s_setup ##1 s_access |-> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_zero: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
        else $error("refused read not zero");
    a_ro_refuse: assert property (pready_o && pwrite_i && paddr_i >= A_REC1
        && paddr_i <= A_STATUS |-> pslverr_o) else $error("read-only write accepted");
    a_reg0_digits: assert property (rd_done && paddr_i == A_REG0 |-> prdata_o < 32'd200
        && prdata_o % 100 < 4) else $error("reg0 digits out of range");
    a_pct_cap: assert property (rd_done && paddr_i inside {8'h38, 8'h3c}
        |-> prdata_o <= 32'd100) else $error("percent above hundred");
    a_test_single: assert property ($onehot0(test_out_o))
        else $error("several test outputs at once");
    a_key_gate: assert property (ser_i.kind == SER_SET_K |=> set_reject_o == !pw_good)
        else $error("setting gate wrong");
    a_digit_set: assert property (disp_o.lit |-> disp_o.digit <= 4'h9 || disp_o.digit == DIG_A)
        else $error("display digit not a register");
endmodule // uvr_rec_asserts

bind uvr_rec uvr_rec_asserts u_chk (.core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .ser_i, .nv_passwd_i, .disp_o, .test_out_o,
    .set_reject_o);

// ---- uvr_link_model.sv ----
// station-side serial model that issues commands to the block
module uvr_link_model (
    input  wire logic         core_clk_i,
    output uvr_pkg::uvr_ser_s ser_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import uvr_pkg::*;
    initial ser_o = '{SER_NONE, 16'h0};
    // idle value inverted so stale data never passes for a command
    task automatic send(input uvr_ser_e k, input logic [15:0] v, input int gap);
        repeat (gap + 1) @(posedge core_clk_i);
        ser_o <= '{k, v};
        @(posedge core_clk_i);
        ser_o <= '{SER_NONE, ~v};
    endtask
endmodule // uvr_link_model

// ---- test_undervoltage_recorded_data_registers.sv ----
// self-checking bench for the undervoltage recorded-data block
module test_undervoltage_recorded_data_registers;
    timeunit 1ns;
    timeprecision 1ns;
    import uvr_pkg::*;
    typedef struct packed {logic [7:0] a; logic w; logic [31:0] d, q; logic e;} uvr_row_s;
    logic        core_clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pready_o, pslverr_o, set_reject_o, step = 1'b0, rbtn = 1'b0, remote = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata_o;
    logic [3:0]  test_out_o;
    logic        link = 1'b1;
    uvr_volt_s   volt = {10'h064, 10'h064, 10'h064};
    uvr_stage_s  stage = 6'h0;
    uvr_ser_s    ser;
    uvr_disp_s   disp_o;
    int          errors = 0, comparisons = 0;
    uvr_row_s    rows [12] = '{'{A_CTRL, 0, 0, 0, 0}, '{A_KMULT, 0, 0, 32'h64, 0},
        '{A_TDEEP, 0, 0, 32'h64, 0}, '{A_USTART, 0, 0, 32'h50, 0}, '{A_BUSADDR, 0, 0, 32'h2a, 0},
        '{A_RATE, 0, 0, 32'h5, 0}, '{A_REC1, 0, 0, 0, 0}, '{A_REC1, 1, 32'h11, 0, 1},
        '{8'h48, 0, 0, 0, 1}, '{8'h02, 0, 0, 0, 1}, '{A_TLOW, 1, 32'h0a, 0, 0},
        '{A_TLOW, 0, 0, 32'h0a, 0}};
    logic [9:0]  recq [8] = '{10'h03c, 10'h064, 10'h02d, 10'h014, 10'h001, 10'h001, 10'h064, 10'h064};
    always #50 core_clk_i = ~core_clk_i;
    uvr_rec #(.TICK_CYCLES(10)) u_dut (.core_clk_i, .rstn_i, .ce_i(1'b1), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o,
        .pready_o, .pslverr_o, .volt_i(volt), .stage_i(stage), .ser_i(ser), .step_btn_i(step),
        .reset_btn_i(rbtn), .remote_reset_i(remote), .link_ok_i(link), .nv_bus_addr_i(8'h2a),
        .nv_rate_i(3'h5), .nv_passwd_i(16'h1234), .disp_o, .test_out_o, .set_reject_o);
    uvr_link_model u_link (.core_clk_i, .ser_o(ser));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ready sampled at the rising edge; request released at that same edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge core_clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge core_clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) errors++;
        rd = prdata_o;
        er = pslverr_o;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic        e;
        apb(a, 1'b0, 32'h0, v, e);
        check(v, exp);
    endtask
    task automatic step_in(input logic [9:0] a, b, c, input logic [5:0] s);
        @(posedge core_clk_i);
        {volt, stage} <= {a, b, c, s};
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic press(input logic s, input logic r);
        @(posedge core_clk_i);
        {step, rbtn} <= {s, r};
        repeat (6) @(posedge core_clk_i);
        {step, rbtn} <= 2'b00;
        repeat (6) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #2000000;
        errors++;
        close_out();
    end
    initial begin
        logic [31:0] v;
        logic        e;
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(disp_o.lit, 32'h0);
        @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(negedge core_clk_i);
        check(disp_o.digit, 32'h1);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d, v, e);
            if (!rows[i].w) check(v, rows[i].q);
            check(e, rows[i].e);
        end
        $display("register table test done");
        step_in(10'h046, 10'h046, 10'h046, 6'h00);
        step_in(10'h046, 10'h046, 10'h046, 6'h20);
        step_in(10'h03c, 10'h03c, 10'h03c, 6'h20);
        step_in(10'h03c, 10'h03c, 10'h03c, 6'h30);
        step_in(10'h032, 10'h032, 10'h032, 6'h30);
        step_in(10'h032, 10'h03c, 10'h028, 6'h00);
        step_in(10'h032, 10'h03c, 10'h028, 6'h08);
        step_in(10'h01e, 10'h02d, 10'h01e, 6'h08);
        step_in(10'h01e, 10'h02d, 10'h01e, 6'h0c);
        step_in(10'h014, 10'h014, 10'h014, 6'h0c);
        step_in(10'h064, 10'h064, 10'h064, 6'h00);
        for (int i = 0; i < 8; i++) rd_chk(A_REC1 + 8'(4 * i), recq[i]);
        $display("recording test done");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk_i);
            remote <= i[2];
            step_in(10'h064, 10'h064, 10'h064, {4'h0, i[0], i[1]});
            rd_chk(A_REG0, 32'(i[2] * 100 + i[1:0]));
        end
        press(1'b1, 1'b0);
        check(disp_o.digit, 32'h2);
        check(disp_o.value, 32'h064);
        press(1'b1, 1'b1);
        check(disp_o.digit, 32'h2);
        rd_chk(A_REC5, 32'h0);
        rd_chk(A_REC7, 32'h0);
        step_in(10'h046, 10'h046, 10'h046, 6'h20);
        step_in(10'h064, 10'h064, 10'h064, 6'h00);
        rd_chk(A_REC5, 32'h1);
        u_link.send(SER_CLEAR, 16'h0, 3);
        rd_chk(A_REC5, 32'h0);
        $display("clear test done");
        u_link.send(SER_SET_K, 16'h0032, 0);
        rd_chk(A_KMULT, 32'h64);
        check(set_reject_o, 32'h1);
        u_link.send(SER_PASSWORD, 16'h1234, 2);
        u_link.send(SER_SET_K, 16'h0032, 0);
        rd_chk(A_KMULT, 32'h32);
        check(set_reject_o, 32'h0);
        $display("password test done");
        press(1'b1, 1'b0);
        check(disp_o.dashes, 32'h1);
        check(disp_o.lit, 32'h1);
        repeat (6) press(1'b1, 1'b0);
        check(disp_o.value, 32'h064);
        press(1'b0, 1'b1);
        press(1'b1, 1'b0);
        check(test_out_o, 32'h1);
        press(1'b0, 1'b1);
        @(posedge core_clk_i);
        link <= 1'b0;
        press(1'b1, 1'b0);
        press(1'b0, 1'b1);
        press(1'b0, 1'b1);
        check(disp_o.digit, 32'ha);
        check(32'(disp_o.value != 10'h000), 32'h1);
        @(posedge core_clk_i);
        link <= 1'b1;
        press(1'b0, 1'b0);
        check(disp_o.value, 32'h0);
        $display("panel test done");
        close_out();
    end
endmodule // test_undervoltage_recorded_data_registers
